// [rtl/swire_dimming_rx.sv]
// single wire dimming receiver: address byte, data byte, open-drain confirm
// Summary of operation
// [RULE1] a frame is an address byte then a data byte
// [RULE2] data byte accepted only when address byte equals device id
// [RULE3] data bit7 confirm request, bits 6:5 register select, 4:0 level
// [RULE4] confirm request bit at one asks for a confirm pulse
// [RULE5] confirm pulse only after a correct frame, by open drain on the pin
// [RULE6] bit rate 1.7k to 160k taken by ratio, no configuration
// [RULE7] host sends register select zero for the level register
// [RULE8] confirm pulse drives the line low, only when requested
// [RULE9] host supplies the pull-up and no push-pull drive
// [RULE10] bits arrive msb first and are shifted in that order
// [RULE11] host holds line high at least 2us before first falling edge
// [RULE12] start interval may be skipped when the line is already high
// [RULE13] high of at least 2us after a bit closes the byte
// [RULE14] high at least twice low is one, low at least twice high is zero
// [RULE15] 5-bit level stored, resets to full scale 31
// [RULE16] a bit spans falling edge to next falling edge
// [RULE17] confirm needs request, address, register match and 16 good bits
// [RULE18] after last falling edge and a delay, drive low at most 512us
// [RULE19] mismatch discards frame, keeps level and line released
// [RULE20] bit with no valid ratio spoils the frame
// [RULE21] no new frame until the confirm drive has ended
`timescale 1ns/1ps
module swire_dimming_rx #(
  parameter logic [7:0]  DEV_ID         = swire_pkg::DEV_ID_DEFAULT,
  parameter int unsigned CLOSE_CYC      = swire_pkg::STREAM_CLOSE_CYC,
  parameter int unsigned VALID_CYC      = swire_pkg::CONFIRM_VALID_CYC,
  parameter int unsigned DRIVE_CYC      = swire_pkg::CONFIRM_DRIVE_CYC,
  parameter int unsigned BIT_MAX        = swire_pkg::BIT_MAX_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic                          wire_in,
  output logic                               wire_out,
  output logic                               wire_oe_n,
  output logic [swire_pkg::LEVEL_W-1:0]      level_q,
  output logic                               level_upd_q,
  output logic                               frame_err_q,
  output logic                               confirm_busy_q
);
  localparam int unsigned W = swire_pkg::TMR_W;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT_VAL, ST_DRIVE
  } rx_state_e;

  rx_state_e                       state_q;
  logic [swire_pkg::SYNC_STAGES-1:0] sync_q;
  logic                            line_q;
  logic                            fall;
  logic                            rise;
  logic [W-1:0]                    high_cnt;
  logic [W-1:0]                    low_cnt;
  logic [W-1:0]                    idle_cnt;
  logic [W-1:0]                    high_now;
  logic [W-1:0]                    wait_q;
  logic [7:0]                      shift_q;
  logic [3:0]                      nbits_q;
  logic                            bit_bad_q;
  logic                            in_bit_q;
  logic                            close_evt;
  logic                            bit_one;
  logic                            bit_zero;
  logic                            timer_clr;

  // three stage synchroniser, change counted when stages 2 and 3 agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_q <= '1;
    end else if (ce) begin
      sync_q <= {sync_q[1:0], wire_in};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_q <= 1'b1;
    end else if (ce && (sync_q[1] == sync_q[2])) begin
      line_q <= sync_q[2];
    end
  end

  assign fall = ce && line_q && (sync_q[1] == sync_q[2]) && !sync_q[2];
  assign rise = ce && !line_q && (sync_q[1] == sync_q[2]) && sync_q[2];
  assign timer_clr = (state_q == ST_WAIT_VAL) || (state_q == ST_DRIVE);

  swire_bit_timer #(
    .W (W)
  ) u_timer (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce),
    .line       (line_q),
    .fall       (fall),
    .rise       (rise),
    .clr        (timer_clr),
    .high_cnt_q (high_cnt),
    .low_cnt_q  (low_cnt),
    .idle_cnt_q (idle_cnt)
  );

  // ratio decode keeps working at any rate within the timer range
  function automatic logic ratio_ge2(input logic [W-1:0] a, input logic [W-1:0] b);
    ratio_ge2 = {1'b0, a} >= {b, 1'b0};
  endfunction

  // the edge that ends a bit still samples high; without it a ratio of two fails
  assign high_now = (&high_cnt) ? high_cnt : high_cnt + W'(1);
  assign bit_one  = ratio_ge2(high_now, low_cnt); // [RULE14] [RULE6]
  assign bit_zero = ratio_ge2(low_cnt, high_now); // [RULE14] [RULE6]
  // a close is a long high after a bit; the bit ends at the close, its high counted up to there
  assign close_evt = ce && in_bit_q && line_q && (idle_cnt == W'(CLOSE_CYC)); // [RULE13]

  // bit boundaries: each falling edge closes the previous bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_q   <= '0;
      nbits_q   <= '0;
      bit_bad_q <= 1'b0;
      in_bit_q  <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_WAIT_VAL || state_q == ST_DRIVE
          || (in_bit_q && idle_cnt >= W'(BIT_MAX))) begin
        // an aborted bit must not leak its count into the next frame
        in_bit_q <= 1'b0; // [RULE21]
      end else if (fall) begin // [RULE16]
        if (in_bit_q) begin
          shift_q <= {shift_q[6:0], bit_one}; // [RULE10]
          nbits_q <= nbits_q + 4'h1;
          if (!bit_one && !bit_zero) begin
            bit_bad_q <= 1'b1; // [RULE20]
          end
        end
        in_bit_q <= 1'b1;
      end else if (close_evt) begin
        // last bit of the byte ends at the close, low vs high so far
        shift_q   <= {shift_q[6:0], bit_one}; // [RULE10]
        if (!bit_one && !bit_zero) begin
          bit_bad_q <= 1'b1; // [RULE20]
        end
        in_bit_q  <= 1'b0;
      end else if (!in_bit_q && state_q == ST_IDLE) begin
        nbits_q   <= '0;
        bit_bad_q <= 1'b0;
      end
      if (close_evt) begin
        nbits_q <= '0;
        if (!bit_one && !bit_zero) begin
          bit_bad_q <= 1'b1;
        end else begin
          bit_bad_q <= 1'b0;
        end
      end
    end
  end

  // frame sequencer
  logic [7:0] byte_now;
  logic       byte_ok;
  assign byte_now = {shift_q[6:0], bit_one};
  assign byte_ok  = (nbits_q == 4'h7) && !bit_bad_q && (bit_one || bit_zero);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      wait_q      <= '0;
      level_q     <= swire_pkg::LEVEL_RESET; // [RULE15]
      level_upd_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (ce) begin
      level_upd_q <= 1'b0;
      frame_err_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (fall) begin
            state_q <= ST_ADDR; // [RULE11] [RULE12]
          end
        end
        ST_ADDR: begin
          if (close_evt) begin
            if (byte_ok && byte_now == DEV_ID) begin // [RULE1] [RULE2]
              state_q <= ST_DATA;
            end else begin
              state_q     <= ST_IDLE; // [RULE19]
              frame_err_q <= 1'b1;
            end
          end else if (in_bit_q && idle_cnt >= W'(BIT_MAX)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_DATA: begin
          if (close_evt) begin
            if (byte_ok && byte_now[swire_pkg::REG_SEL_HI:swire_pkg::REG_SEL_LO]
                == swire_pkg::REG_SEL_LEVEL) begin // [RULE3] [RULE7]
              level_q     <= byte_now[swire_pkg::LEVEL_HI:0]; // [RULE15]
              level_upd_q <= 1'b1;
              if (byte_now[swire_pkg::CONFIRM_POS]) begin // [RULE4] [RULE17]
                state_q <= ST_WAIT_VAL;
                wait_q  <= '0;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              state_q     <= ST_IDLE; // [RULE19] [RULE20]
              frame_err_q <= 1'b1;
            end
          end else if (in_bit_q && idle_cnt >= W'(BIT_MAX)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WAIT_VAL: begin
          if (wait_q >= W'(VALID_CYC - 1)) begin // [RULE18]
            state_q <= ST_DRIVE;
            wait_q  <= '0;
          end else begin
            wait_q <= wait_q + W'(1);
          end
        end
        ST_DRIVE: begin
          if (wait_q >= W'(DRIVE_CYC - 1)) begin // [RULE18] [RULE21]
            state_q <= ST_IDLE;
            wait_q  <= '0;
          end else begin
            wait_q <= wait_q + W'(1);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // open drain: output enable low while pulling the line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wire_out       <= 1'b0;
      wire_oe_n      <= 1'b1;
      confirm_busy_q <= 1'b0;
    end else if (ce) begin
      wire_out       <= 1'b0; // [RULE8]
      wire_oe_n      <= !(state_q == ST_DRIVE); // [RULE5] [RULE8]
      confirm_busy_q <= (state_q == ST_WAIT_VAL) || (state_q == ST_DRIVE);
    end
  end

  // drive window never exceeds its bound
  logic [W-1:0] drv_len_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drv_len_q <= '0;
    end else if (ce) begin
      drv_len_q <= !wire_oe_n ? drv_len_q + W'(1) : '0;
    end
  end

  property p_drive_bound;
    @(posedge clk) disable iff (!rstn) drv_len_q <= W'(DRIVE_CYC);
  endproperty
  a_drive_bound: assert property (p_drive_bound) else $error("confirm drive too long"); // [RULE18]

  property p_drive_low;
    @(posedge clk) disable iff (!rstn) !wire_oe_n |-> !wire_out;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("confirm not low"); // [RULE8]

  property p_drive_cause;
    @(posedge clk) disable iff (!rstn)
      $fell(wire_oe_n) |-> $past(state_q) == ST_DRIVE;
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("drive without frame"); // [RULE5]

  property p_level_keep;
    @(posedge clk) disable iff (!rstn) !level_upd_q |-> $stable(level_q) || !ce;
  endproperty
  a_level_keep: assert property (p_level_keep) else $error("level changed"); // [RULE19]

  property p_no_rx_busy;
    @(posedge clk) disable iff (!rstn) confirm_busy_q |-> !level_upd_q;
  endproperty
  a_no_rx_busy: assert property (p_no_rx_busy) else $error("frame while busy"); // [RULE21]

  property p_wait_first;
    @(posedge clk) disable iff (!rstn)
      (state_q == ST_DATA && close_evt && byte_ok
       && byte_now[swire_pkg::CONFIRM_POS]
       && byte_now[6:5] == swire_pkg::REG_SEL_LEVEL) |=> state_q == ST_WAIT_VAL;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no confirm wait"); // [RULE17]

  property p_no_req_no_drive;
    @(posedge clk) disable iff (!rstn)
      (state_q == ST_DATA && close_evt && !byte_now[swire_pkg::CONFIRM_POS])
      |=> state_q != ST_WAIT_VAL;
  endproperty
  a_no_req_no_drive: assert property (p_no_req_no_drive) else $error("confirm unasked"); // [RULE4]

  property p_addr_gate;
    @(posedge clk) disable iff (!rstn)
      (state_q == ST_ADDR && close_evt && byte_now != DEV_ID) |=> state_q == ST_IDLE;
  endproperty
  a_addr_gate: assert property (p_addr_gate) else $error("bad address taken"); // [RULE2]

  c_update:  cover property (@(posedge clk) disable iff (!rstn) level_upd_q);
  c_confirm: cover property (@(posedge clk) disable iff (!rstn) $fell(wire_oe_n));
  c_error:   cover property (@(posedge clk) disable iff (!rstn) frame_err_q);
endmodule

// [inc/swire_pkg.sv]
// constants for the single wire dimming receiver
package swire_pkg;
  localparam int unsigned CLK_HZ              = 20_000_000;
  // times in nanoseconds
  localparam int unsigned STREAM_CLOSE_NS     = 2_000;
  localparam int unsigned CONFIRM_DRIVE_NS    = 512_000;
  localparam int unsigned CONFIRM_VALID_NS    = 2_000;
  // slowest bit 1/1.7k s = 588236 ns, guard against a stuck line
  localparam int unsigned BIT_MAX_NS          = 588_236;
  localparam int unsigned NS_PER_CYC          = 1_000_000_000 / CLK_HZ;
  // least times round up, longest times round down
  localparam int unsigned STREAM_CLOSE_CYC    = (STREAM_CLOSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned CONFIRM_DRIVE_CYC   = CONFIRM_DRIVE_NS / NS_PER_CYC;
  localparam int unsigned CONFIRM_VALID_CYC   = (CONFIRM_VALID_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned BIT_MAX_CYC         = BIT_MAX_NS / NS_PER_CYC;
  localparam int unsigned TMR_W               = 16;
  localparam int unsigned BYTE_W              = 8;
  localparam int unsigned LEVEL_W             = 5;
  // data byte layout
  localparam int unsigned CONFIRM_POS         = 7;
  localparam int unsigned REG_SEL_HI          = 6;
  localparam int unsigned REG_SEL_LO          = 5;
  localparam int unsigned LEVEL_HI            = 4;
  localparam logic [1:0]  REG_SEL_LEVEL       = 2'h0;
  localparam logic [4:0]  LEVEL_RESET         = 5'h1f;
  // arbitrary neutral device address
  localparam logic [7:0]  DEV_ID_DEFAULT      = 8'h5a;
  localparam int unsigned SYNC_STAGES         = 3;
endpackage

// [rtl/swire_bit_timer.sv]
// measures high and low phases of one bit between falling edges
`timescale 1ns/1ps
module swire_bit_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         line,
  input  wire logic         fall,
  input  wire logic         rise,
  input  wire logic         clr,
  output logic [W-1:0]      high_cnt_q,
  output logic [W-1:0]      low_cnt_q,
  output logic [W-1:0]      idle_cnt_q
);
  // saturating add avoids wrap on very slow hosts
  function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v);
    sat_inc = (&v) ? v : v + {{(W-1){1'b0}}, 1'b1};
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_cnt_q <= '0;
      low_cnt_q  <= '0;
    end else if (ce) begin
      if (fall || clr) begin
        high_cnt_q <= '0;
        low_cnt_q  <= '0;
      end else if (line) begin
        high_cnt_q <= sat_inc(high_cnt_q);
      end else begin
        low_cnt_q <= sat_inc(low_cnt_q);
      end
    end
  end

  // time since the last edge of either kind
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_q <= '0;
    end else if (ce) begin
      if (fall || rise || clr) begin
        idle_cnt_q <= '0;
      end else begin
        idle_cnt_q <= sat_inc(idle_cnt_q);
      end
    end
  end
endmodule

// [testbench/swire_host_model.sv]
// host side model: open-drain master with pull-up on the single wire
`timescale 1ns/1ps
module swire_host_model #(
  parameter int unsigned CLOSE_N = 46,
  parameter int unsigned HOLD_N  = 4
) (
  input  wire logic clk,
  input  wire logic dev_oe_n,
  output logic      line
);
  logic host_low;
  logic ack_seen;

  // pull-up unless a party sinks the line; host never drives high
  assign line = (host_low || !dev_oe_n) ? 1'b0 : 1'b1;

  initial begin
    host_low = 1'b0;
    ack_seen = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // low phase then high phase; the next fall closes the bit
  task automatic send_bit(input int lo, input int hi);
    host_low = 1'b1;
    wait_cyc(lo);
    host_low = 1'b0;
    wait_cyc(hi);
  endtask

  // bad picks one bit sent with equal phases, -1 for none
  task automatic send_byte(input logic [7:0] v, input int s, input int l, input int bad);
    // close counts from the last rise, so a last zero needs a low twice as long
    for (int i = 7; i >= 0; i--) begin
      if (i == bad)
        send_bit(l, l);
      else if (i == 0)
        send_bit(v[i] ? s : 2 * CLOSE_N, 0);
      else if (v[i])
        send_bit(s, l);
      else
        send_bit(l, s);
    end
    wait_cyc(CLOSE_N);
  endtask

  // line already high from the last close, so no extra start interval
  task automatic send_frame(input logic [7:0] addr, input logic [7:0] data,
                            input int s, input int l, input int bad);
    ack_seen = 1'b0;
    send_byte(addr, s, l, -1);
    send_byte(data, s, l, bad);
    if (data[7]) begin
      // hold low through the validation delay, then release and listen
      host_low = 1'b1;
      wait_cyc(HOLD_N);
      host_low = 1'b0;
    end
    // a rejected frame reads our low pulse as a new byte; let it close here
    repeat (CLOSE_N + 24) begin
      @(negedge clk);
      if (line === 1'b0)
        ack_seen = 1'b1;
    end
  endtask
endmodule

// [testbench/tb_top.sv]
// bench top: host model, receiver and reference expectations
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0]  DEV_ID  = 8'h3c; // arbitrary value
  localparam int unsigned DRIVE_N = 20;
  localparam int unsigned VALID_N = 4;

  logic       clk;
  logic       rstn;
  logic       ce;
  logic       wire_in;
  logic       wire_out;
  logic       wire_oe_n;
  logic [4:0] level_q;
  logic       level_upd_q;
  logic       frame_err_q;
  logic       confirm_busy_q;
  logic [7:0] d;
  int         miscompares;
  int         cmp_count;
  int         seed;
  int         exp_level;
  int         upd_cnt;
  int         err_cnt;
  int         low_run;
  int         last_run;
  int         u;
  int         busy_cnt;

  swire_host_model host (
    .clk      (clk),
    .dev_oe_n (wire_oe_n),
    .line     (wire_in)
  );

  // short delay and drive keep the run brief; close stays at the 40-cycle default
  swire_dimming_rx #(
    .DEV_ID    (DEV_ID),
    .CLOSE_CYC (40),
    .VALID_CYC (VALID_N),
    .DRIVE_CYC (DRIVE_N),
    .BIT_MAX   (2000)
  ) dut (
    .clk            (clk),
    .rstn           (rstn),
    .ce             (ce),
    .wire_in        (wire_in),
    .wire_out       (wire_out),
    .wire_oe_n      (wire_oe_n),
    .level_q        (level_q),
    .level_upd_q    (level_upd_q),
    .frame_err_q    (frame_err_q),
    .confirm_busy_q (confirm_busy_q)
  );

  always #25 clk = ~clk;

  // pulse counts and length of each confirm drive
  always @(posedge clk) begin
    if (level_upd_q === 1'b1)
      upd_cnt++;
    if (confirm_busy_q === 1'b1)
      busy_cnt++;
    if (frame_err_q === 1'b1)
      err_cnt++;
    if (wire_oe_n === 1'b0)
      low_run++;
    else if (low_run != 0) begin
      last_run = low_run;
      low_run = 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reference: only a clean frame to our id and register 0 loads and confirms
  task automatic run_frame(input logic [7:0] addr, input logic [7:0] data,
                           input int s, input int l, input int bad);
    logic good;
    logic ack;
    upd_cnt = 0;
    err_cnt = 0;
    last_run = 0;
    busy_cnt = 0;
    good = (addr == DEV_ID) && (data[6:5] == 2'h0) && (bad < 0);
    ack = good && data[7];
    host.send_frame(addr, data, s, l, bad);
    if (good)
      exp_level = int'(data[4:0]);
    check(32'(level_q), 32'(exp_level));
    check(32'(upd_cnt), 32'(good));
    check(32'(err_cnt != 0), 32'(!good));
    check(32'(host.ack_seen), 32'(ack));
    check(32'(last_run), ack ? 32'(DRIVE_N) : 32'h0);
    check(32'(busy_cnt), ack ? 32'(VALID_N + DRIVE_N) : 32'h0);
    check(32'(wire_out), 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    seed = 39563;
    miscompares = 0;
    cmp_count = 0;
    exp_level = 31;
    upd_cnt = 0;
    err_cnt = 0;
    low_run = 0;
    last_run = 0;
    busy_cnt = 0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    check(32'(level_q), 32'h1f);
    check(32'(wire_oe_n), 32'h1);
    host.wait_cyc(60);
    // several bit rates, with the ratio of exactly two among them
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      d[6:5] = 2'h0;
      u = 4 + (i % 3) * 3;
      run_frame(DEV_ID, d, u, (i % 4 == 0) ? 2 * u : 3 * u, -1);
    end
    $display("test good frames done");
    for (int r = 1; r < 4; r++)
      run_frame(DEV_ID, {1'b1, 2'(r), 5'h0a}, 6, 18, -1);
    $display("test register select done");
    for (int b = 0; b < 8; b++)
      run_frame(DEV_ID ^ (8'h01 << b), 8'h85, 6, 18, -1);
    $display("test address mismatch done");
    // last bit is judged against the close, so spoil earlier bits only
    for (int b = 1; b < 8; b += 3)
      run_frame(DEV_ID, 8'h93, 6, 18, b);
    $display("test bad ratio done");
    run_frame(DEV_ID, 8'h80, 5, 15, -1);
    $display("test zero level done");
    // clock enable low: a whole frame to our id must leave no trace
    ce = 1'b0;
    upd_cnt = 0;
    busy_cnt = 0;
    host.send_frame(DEV_ID, 8'h85, 6, 18, -1);
    ce = 1'b1;
    check(32'(level_q), 32'(exp_level));
    check(32'(upd_cnt + busy_cnt), 32'h0);
    check(32'(host.ack_seen), 32'h0);
    $display("test clock enable done");
    complete_run;
  end

  // about 28 frames of about 650 cycles each
  initial begin
    #(60_000 * 50);
    miscompares++;
    complete_run;
  end
endmodule
